/* File: hdl/host_pwr_pkg.sv */
// Constants, field layouts and carrier types for the host power/reset watchdog
package host_pwr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_PERIOD_NS = 31_250_000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 21;
  localparam int TICKS_PER_SEC = 32;
  localparam int HOLD_SEC = 4;
  localparam int HOLD_TICKS = HOLD_SEC * TICKS_PER_SEC;
  localparam int PRESS_MS = 250;
  localparam int PRESS_TICKS = (PRESS_MS * TICKS_PER_SEC) / 1000;
  localparam int RESET_PULSE_SEC = 1;
  localparam int RESET_PULSE_TICKS = RESET_PULSE_SEC * TICKS_PER_SEC;
  localparam int EXTRA_HOLD_SEC = 5;
  localparam int EXTRA_HOLD_TICKS = EXTRA_HOLD_SEC * TICKS_PER_SEC;
  localparam int REBOOT_TICKS = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Function mask bit positions
  localparam int MASK_AUTO_POL = 0;
  localparam int MASK_RST_INV = 1;
  localparam int MASK_PWR_INV = 2;
  localparam int MASK_BLANK = 4;
  localparam int MASK_KEY_RESET = 5;
  localparam int MASK_KEY_WAKE = 6;
  localparam int MASK_KEY_OFF = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Register map and field positions
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_SWITCH_CFG = 4'h0;
  localparam logic [3:0] ADDR_WDOG = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_ACK = 4'h3;
  localparam int CFG_MASK_LSB = 0;
  localparam int CFG_LEN_LSB = 8;
  localparam int CFG_LEN_VALID = 16;
  localparam int CFG_SENSE_VALID = 17;
  localparam int CFG_SENSE_SEL = 18;
  localparam int STAT_MASK_LSB = 0;
  localparam int STAT_WDOG_LSB = 8;
  localparam int STAT_SENSE_SEL = 16;
  localparam int STAT_LEN_LSB = 20;
  localparam int STAT_TYPE_LSB = 24;

  ////////////////////////////////////////////////////////////////////////////
  // Codes and reset values
  localparam logic [7:0] ACK_SWITCH_CFG = 8'h5C;
  localparam logic [7:0] ACK_WDOG = 8'h5D;
  localparam logic [7:0] STATUS_TYPE = 8'h5E;
  localparam logic [3:0] STATUS_LEN = 4'hF;
  localparam logic [7:0] PULSE_HOLD = 8'hFF;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_PULSE_LEN = 8'h20;
  localparam logic RST_SENSE_SEL = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RST_PULSE = 3'b001,
    ST_WAKE_PULSE = 3'b010,
    ST_OFF_PULSE = 3'b011,
    ST_OFF_EXTEND = 3'b100,
    ST_REBOOT = 3'b101
  } state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [31:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic confirm;
    logic cancel;
    logic sense_pin;
    logic aux_detect;
    logic rst_line;
    logic pwr_line;
  } pins_in_t;

  typedef struct packed {
    logic out;
    logic oe;
  } line_t;

endpackage

/* File: hdl/pin_sync.sv */
// Two-stage synchroniser for all asynchronous pin inputs
`timescale 1ns/1ns
module pin_sync
  import host_pwr_pkg::*;
(
  // Clock, reset and enable
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  // Raw and synchronised pins
  input wire host_pwr_pkg::pins_in_t i_pins,
  output host_pwr_pkg::pins_in_t o_pins
);

  typedef struct packed {
    pins_in_t meta;
    pins_in_t sync;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.meta = i_pins;
    s_d.sync = s_q.meta;
  end

  // Follows the pins through reset, so sense and line levels are settled on release
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || i_clk_en) begin
      s_q <= s_d;
    end
  end

  assign o_pins = s_q.sync;

endmodule

/* File: hdl/host_power_reset_watchdog.sv */
// Host power switch, reset line and watchdog controller
// Summary of operation
// - Both lines float when idle; driven to active level only during a pulse.
// - Mask bit0 auto polarity, bit1 reset drives high, bit2 power drives high.
// - Key-reset enabled, host up: confirm held 4 s pulses reset 1 s, then reboot.
// - After a key reset pulse, register writes are ignored until reboot ends.
// - Wake enabled, host down: confirm 0.25 s pulses power line, then reboot.
// - Shutdown enabled, host up: cancel held 4 s pulses power line configured length.
// - Cancel still held after shutdown pulse keeps driving, at most 5 s more.
// - Mask bit4 blanks display and backlight while host sense is low.
// - Sense select 1 (default) uses aux supply detect, 0 uses sense pin.
// - Device stays active while host is off; sense rising reboots the device.
// - Mask bit5 key reset, bit6 key wake, bit7 key shutdown enable.
// - Pulse length in 1/32 s units; 255 holds until host power changes.
// - Watchdog 0 disables, 1-255 seconds; expiry pulses the host reset.
// - Watchdog off at power-up and after it has fired until rearmed.
// - Watchdog command carries one timeout byte, acknowledged with 0x5D.
// - Status readback tags 0x5E, 15 bytes: mask, watchdog count, sense select.
`timescale 1ns/1ns
module host_power_reset_watchdog
  import host_pwr_pkg::*;
#(
  parameter int TICK_CYCLES_P = host_pwr_pkg::TICK_CYCLES
)
(
  // Clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  // Register port
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_rdata,
  // Command acknowledge
  output logic o_ack_valid,
  output logic [7:0] o_ack_type,
  // Keys and sense inputs
  input wire logic i_key_confirm,
  input wire logic i_key_cancel,
  input wire logic i_sense_pin,
  input wire logic i_aux_supply_detect,
  // Host reset line (open drain)
  input wire logic i_rst_line_i,
  output logic o_rst_line_o,
  output logic o_rst_line_oe,
  // Host power switch line (open drain)
  input wire logic i_pwr_line_i,
  output logic o_pwr_line_o,
  output logic o_pwr_line_oe,
  // Device-side effects
  output logic o_display_blank,
  output logic o_backlight_off,
  output logic o_self_restart,
  output logic o_cmd_locked
);
  import host_pwr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    state_t state;
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    logic [7:0] confirm_cnt;
    logic [7:0] cancel_cnt;
    logic [7:0] pulse_cnt;
    logic [7:0] extend_cnt;
    logic hold_sense;
    logic reboot_after;
    logic [7:0] mask;
    logic [7:0] pulse_len;
    logic sense_sel;
    logic [7:0] wd_count;
    logic [4:0] wd_sub;
    logic sense_prev;
    logic idle_rst_lvl;
    logic idle_pwr_lvl;
    line_t rst_line;
    line_t pwr_line;
    logic [31:0] rdata;
    logic ack_valid;
    logic [7:0] ack_type;
    logic self_restart;
    logic blank;
  } ctl_state_t;

  ctl_state_t s_q;
  ctl_state_t s_d;
  pins_in_t pins_raw;
  pins_in_t sy;
  bus_req_t req;
  logic sense;
  logic rst_lvl;
  logic pwr_lvl;
  logic locked;
  logic [7:0] eff_len;
  logic pulse_done;

  assign req = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};
  assign pins_raw = '{confirm: i_key_confirm, cancel: i_key_cancel, sense_pin: i_sense_pin,
                      aux_detect: i_aux_supply_detect, rst_line: i_rst_line_i,
                      pwr_line: i_pwr_line_i};

  pin_sync u_pin_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_clk_en(i_clk_en),
    .i_pins(pins_raw),
    .o_pins(sy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    s_d.ack_valid = 1'b0;
    s_d.self_restart = 1'b0;
    s_d.rdata = '0;

    // Common 1/32 s tick
    if (s_q.tick_cnt == TICK_W'(TICK_CYCLES_P - 1)) begin
      s_d.tick_cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + 1'b1;
    end

    sense = s_q.sense_sel ? sy.aux_detect : sy.sense_pin;
    s_d.sense_prev = sense;
    s_d.blank = s_q.mask[MASK_BLANK] & ~sense;

    // Active level: auto drives opposite to the idle level seen on the line
    rst_lvl = s_q.mask[MASK_AUTO_POL] ? ~s_q.idle_rst_lvl : s_q.mask[MASK_RST_INV];
    pwr_lvl = s_q.mask[MASK_AUTO_POL] ? ~s_q.idle_pwr_lvl : s_q.mask[MASK_PWR_INV];

    eff_len = (s_q.pulse_len == 8'h00) ? RST_PULSE_LEN : s_q.pulse_len;
    if (eff_len == PULSE_HOLD) begin
      pulse_done = (sense != s_q.hold_sense);
    end else begin
      pulse_done = s_q.tick && (s_q.pulse_cnt <= 8'h01);
    end
    locked = (s_q.state == ST_REBOOT);

    // Key hold timers count only in idle
    if (s_q.state != ST_IDLE) begin
      s_d.confirm_cnt = '0;
      s_d.cancel_cnt = '0;
    end else if (s_q.tick) begin
      if (!sy.confirm) begin
        s_d.confirm_cnt = '0;
      end else if (s_q.confirm_cnt != 8'hFF) begin
        s_d.confirm_cnt = s_q.confirm_cnt + 1'b1;
      end
      if (!sy.cancel) begin
        s_d.cancel_cnt = '0;
      end else if (s_q.cancel_cnt != 8'hFF) begin
        s_d.cancel_cnt = s_q.cancel_cnt + 1'b1;
      end
    end

    if (s_q.tick && s_q.state != ST_IDLE && s_q.pulse_cnt != 8'h00) begin
      s_d.pulse_cnt = s_q.pulse_cnt - 1'b1;
    end

    case (s_q.state)
      ST_IDLE: begin
        s_d.idle_rst_lvl = sy.rst_line;
        s_d.idle_pwr_lvl = sy.pwr_line;
        if (s_q.tick && s_q.wd_count != 8'h00) begin
          s_d.wd_sub = s_q.wd_sub + 1'b1;
          if (s_q.wd_sub == 5'h1F) begin
            s_d.wd_count = s_q.wd_count - 1'b1;
          end
        end
        if (s_q.tick && s_q.wd_count == 8'h01 && s_q.wd_sub == 5'h1F) begin
          // Expiry leaves the count at zero, so it stays off until rearmed
          s_d.state = ST_RST_PULSE;
          s_d.pulse_cnt = 8'(RESET_PULSE_TICKS);
          s_d.reboot_after = 1'b0;
        end else if (sense && !s_q.sense_prev) begin
          s_d.state = ST_REBOOT;
          s_d.pulse_cnt = 8'(REBOOT_TICKS);
        end else if (s_q.mask[MASK_KEY_RESET] && sense &&
                     s_q.confirm_cnt >= 8'(HOLD_TICKS)) begin
          s_d.state = ST_RST_PULSE;
          s_d.pulse_cnt = 8'(RESET_PULSE_TICKS);
          s_d.reboot_after = 1'b1;
        end else if (s_q.mask[MASK_KEY_WAKE] && !sense &&
                     s_q.confirm_cnt >= 8'(PRESS_TICKS)) begin
          s_d.state = ST_WAKE_PULSE;
          s_d.pulse_cnt = eff_len;
          s_d.hold_sense = sense;
        end else if (s_q.mask[MASK_KEY_OFF] && sense &&
                     s_q.cancel_cnt >= 8'(HOLD_TICKS)) begin
          s_d.state = ST_OFF_PULSE;
          s_d.pulse_cnt = eff_len;
          s_d.hold_sense = sense;
        end
      end
      ST_RST_PULSE: begin
        if (s_q.tick && s_q.pulse_cnt <= 8'h01) begin
          if (s_q.reboot_after) begin
            s_d.state = ST_REBOOT;
            s_d.pulse_cnt = 8'(REBOOT_TICKS);
          end else begin
            s_d.state = ST_IDLE;
          end
        end
      end
      ST_WAKE_PULSE: begin
        if (pulse_done) begin
          s_d.state = ST_REBOOT;
          s_d.pulse_cnt = 8'(REBOOT_TICKS);
        end
      end
      ST_OFF_PULSE: begin
        if (pulse_done) begin
          if (sy.cancel) begin
            s_d.state = ST_OFF_EXTEND;
            s_d.extend_cnt = 8'(EXTRA_HOLD_TICKS);
          end else begin
            s_d.state = ST_IDLE;
          end
        end
      end
      ST_OFF_EXTEND: begin
        if (s_q.tick) begin
          s_d.extend_cnt = s_q.extend_cnt - 1'b1;
        end
        if (!sy.cancel || (s_q.tick && s_q.extend_cnt <= 8'h01)) begin
          s_d.state = ST_IDLE;
        end
      end
      ST_REBOOT: begin
        if (s_q.tick) begin
          // Restart as from power-up; settings kept as the boot state
          s_d.state = ST_IDLE;
          s_d.self_restart = 1'b1;
          s_d.wd_count = '0;
          s_d.wd_sub = '0;
          s_d.reboot_after = 1'b0;
        end
      end
      default: begin
        s_d.state = ST_IDLE;
      end
    endcase

    // Lines float unless a pulse drives them
    s_d.rst_line.oe = (s_d.state == ST_RST_PULSE);
    s_d.rst_line.out = rst_lvl;
    s_d.pwr_line.oe = (s_d.state == ST_WAKE_PULSE) || (s_d.state == ST_OFF_PULSE) ||
                      (s_d.state == ST_OFF_EXTEND);
    s_d.pwr_line.out = pwr_lvl;

    //////////////////////////////////////////////////////////////////////////
    // Register writes
    if (req.wr && !locked) begin
      if (req.addr == ADDR_SWITCH_CFG) begin
        s_d.mask = req.wdata[CFG_MASK_LSB +: 8];
        if (req.wdata[CFG_LEN_VALID]) begin
          s_d.pulse_len = req.wdata[CFG_LEN_LSB +: 8];
        end
        if (req.wdata[CFG_SENSE_VALID]) begin
          s_d.sense_sel = req.wdata[CFG_SENSE_SEL];
        end
        s_d.ack_valid = 1'b1;
        s_d.ack_type = ACK_SWITCH_CFG;
      end else if (req.addr == ADDR_WDOG) begin
        s_d.wd_count = req.wdata[7:0];
        s_d.wd_sub = '0;
        s_d.ack_valid = 1'b1;
        s_d.ack_type = ACK_WDOG;
      end
    end

    // Register reads
    if (req.rd) begin
      if (req.addr == ADDR_SWITCH_CFG) begin
        s_d.rdata[CFG_MASK_LSB +: 8] = s_q.mask;
        s_d.rdata[CFG_LEN_LSB +: 8] = s_q.pulse_len;
        s_d.rdata[CFG_SENSE_SEL] = s_q.sense_sel;
      end else if (req.addr == ADDR_WDOG) begin
        s_d.rdata[7:0] = s_q.wd_count;
      end else if (req.addr == ADDR_STATUS) begin
        s_d.rdata[STAT_MASK_LSB +: 8] = s_q.mask;
        s_d.rdata[STAT_WDOG_LSB +: 8] = s_q.wd_count;
        s_d.rdata[STAT_SENSE_SEL] = s_q.sense_sel;
        s_d.rdata[STAT_LEN_LSB +: 4] = STATUS_LEN;
        s_d.rdata[STAT_TYPE_LSB +: 8] = STATUS_TYPE;
      end else if (req.addr == ADDR_ACK) begin
        s_d.rdata[7:0] = s_q.ack_type;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s_q <= '0;
      s_q.mask <= RST_MASK;
      s_q.pulse_len <= RST_PULSE_LEN;
      s_q.sense_sel <= RST_SENSE_SEL;
      s_q.idle_rst_lvl <= 1'b1;
      s_q.idle_pwr_lvl <= 1'b1;
      s_q.sense_prev <= 1'b1;
    end else if (i_clk_en) begin
      s_q <= s_d;
    end
  end

  assign o_rdata = s_q.rdata;
  assign o_ack_valid = s_q.ack_valid;
  assign o_ack_type = s_q.ack_type;
  assign o_rst_line_o = s_q.rst_line.out;
  assign o_rst_line_oe = s_q.rst_line.oe;
  assign o_pwr_line_o = s_q.pwr_line.out;
  assign o_pwr_line_oe = s_q.pwr_line.oe;
  assign o_display_blank = s_q.blank;
  assign o_backlight_off = s_q.blank;
  assign o_self_restart = s_q.self_restart;
  assign o_cmd_locked = (s_q.state == ST_REBOOT);

endmodule

/* File: verification/host_board_model.sv */
// Host board model: pulled-up switch lines and a supply toggled by the power line
`timescale 1ns/1ns
module host_board_model (
  // Clock and test control
  input wire logic i_sys_clk,
  input wire logic i_force,
  input wire logic i_force_on,
  // Lines from the controller
  input wire logic i_rst_o,
  input wire logic i_rst_oe,
  input wire logic i_pwr_o,
  input wire logic i_pwr_oe,
  // Board side
  output logic o_rst_line,
  output logic o_pwr_line,
  output logic o_host_on
);
  logic pwr_oe_q = 1'b0;
  // Released lines float up to the pull-up level
  assign o_rst_line = i_rst_oe ? i_rst_o : 1'b1;
  assign o_pwr_line = i_pwr_oe ? i_pwr_o : 1'b1;
  initial o_host_on = 1'b0;
  always @(posedge i_sys_clk) begin
    pwr_oe_q <= i_pwr_oe;
    if (i_force) begin
      o_host_on <= i_force_on;
    end else if (pwr_oe_q && !i_pwr_oe) begin
      // Supply changes state when a button press ends
      o_host_on <= !o_host_on;
    end
  end
endmodule

/* File: verification/host_power_reset_watchdog_asserts.sv */
// Checker for the host power, reset and watchdog controller
`timescale 1ns/1ns
module host_pwr_asserts #(
  parameter int TICK_CYCLES_P = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [3:0] i_addr,
  input logic [31:0] o_rdata,
  input logic o_ack_valid,
  input logic [7:0] o_ack_type,
  input logic o_rst_line_o,
  input logic o_rst_line_oe,
  input logic o_pwr_line_oe,
  input logic o_self_restart,
  input logic o_cmd_locked
);
  localparam int LO = 31 * TICK_CYCLES_P;
  localparam int HI = 33 * TICK_CYCLES_P;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////////
  // Cycles the reset line has been driven
  always_comb cnt_d = o_rst_line_oe ? cnt_q + 16'h1 : 16'h0;
  always_ff @(posedge i_sys_clk) cnt_q <= i_rst ? 16'h0 : cnt_d;
  ////////////////////////////////////////////////////////////////////////
  property p_cfg_ack;
    i_wr && i_addr == 4'h0 && !o_cmd_locked |=> o_ack_valid && o_ack_type == 8'h5C;
  endproperty
  a_cfg_ack: assert property (p_cfg_ack) else $error("config ack wrong");
  property p_wdog_ack;
    i_wr && i_addr == 4'h1 && !o_cmd_locked |=> o_ack_valid && o_ack_type == 8'h5D;
  endproperty
  a_wdog_ack: assert property (p_wdog_ack) else $error("watchdog ack wrong");
  property p_lock_drop;
    i_wr && o_cmd_locked |=> !o_ack_valid;
  endproperty
  a_lock_drop: assert property (p_lock_drop) else $error("write taken while locked");
  property p_status;
    i_rd && i_addr == 4'h2 |=> o_rdata[31:20] == 12'h5EF;
  endproperty
  a_status: assert property (p_status) else $error("status header wrong");
  property p_rd_idle;
    !i_rd |=> o_rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
  property p_rst_level;
    o_rst_line_oe && $past(o_rst_line_oe) |-> $stable(o_rst_line_o);
  endproperty
  a_rst_level: assert property (p_rst_level) else $error("reset level moved");
  property p_rst_len;
    $fell(o_rst_line_oe) |-> cnt_q >= LO && cnt_q <= HI;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset pulse length wrong");
  property p_restart;
    o_self_restart |-> $past(o_cmd_locked) ##1 !o_self_restart;
  endproperty
  a_restart: assert property (p_restart) else $error("self restart not after lock");
  c_rst: cover property ($fell(o_rst_line_oe));
  c_pwr: cover property ($fell(o_pwr_line_oe));
  c_boot: cover property (o_self_restart);
endmodule
bind host_power_reset_watchdog host_pwr_asserts #(.TICK_CYCLES_P(TICK_CYCLES_P)) i_chk (
  .i_sys_clk, .i_rst, .i_wr, .i_rd, .i_addr, .o_rdata, .o_ack_valid, .o_ack_type,
  .o_rst_line_o, .o_rst_line_oe, .o_pwr_line_oe, .o_self_restart, .o_cmd_locked
);

/* File: verification/tb.sv */
// Self-checking bench for the host power, reset and watchdog controller
`timescale 1ns/1ns
module tb;
  import host_pwr_pkg::*;
  localparam int T = 4;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_prev = 1'b0;
  logic confirm = 1'b0, cancel = 1'b0, sense_pin = 1'b1, host_set = 1'b1, force_on = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic ack_valid, rst_o, rst_oe, pwr_o, pwr_oe, blank, bl_off, restart, locked;
  logic rst_line, pwr_line, host_on;
  logic [7:0] ack_type;
  logic [1:0] lvl, oes, lines;
  logic [5:0] sig;
  logic [31:0] ack_q[$], rd_q[$], pulse_q[$];
  int bad_count = 0, compares = 0, seed = 32'h32ffb846, len;
  int n[2] = '{0, 0};
  always #10 clk = ~clk;
  assign sig = {host_on, ~host_on, restart, locked, pwr_oe, rst_oe};
  assign oes = {pwr_oe, rst_oe};
  assign lines = {pwr_line, rst_line};
  host_power_reset_watchdog #(.TICK_CYCLES_P(T)) i_dut (
    .i_sys_clk(clk), .i_rst(rst), .i_clk_en(1'b1), .i_wr(wr), .i_rd(rd), .i_addr(addr),
    .i_wdata(wdata), .o_rdata(rdata), .o_ack_valid(ack_valid), .o_ack_type(ack_type),
    .i_key_confirm(confirm), .i_key_cancel(cancel), .i_sense_pin(sense_pin),
    .i_aux_supply_detect(host_on), .i_rst_line_i(rst_line), .o_rst_line_o(rst_o),
    .o_rst_line_oe(rst_oe), .i_pwr_line_i(pwr_line), .o_pwr_line_o(pwr_o),
    .o_pwr_line_oe(pwr_oe), .o_display_blank(blank), .o_backlight_off(bl_off),
    .o_self_restart(restart), .o_cmd_locked(locked));
  host_board_model i_host (
    .i_sys_clk(clk), .i_force(host_set), .i_force_on(force_on), .i_rst_o(rst_o),
    .i_rst_oe(rst_oe), .i_pwr_o(pwr_o), .i_pwr_oe(pwr_oe), .o_rst_line(rst_line),
    .o_pwr_line(pwr_line), .o_host_on(host_on));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cmp_rdata(logic [31:0] exp, logic [31:0] got);
    chk("rdata", exp, got);
  endtask
  task automatic cmp_ack(logic [31:0] exp, logic [31:0] got);
    chk("ack", exp, got);
  endtask
  task automatic cmp_pulse(logic [31:0] exp, logic [31:0] got);
    chk("pulse", exp, got);
  endtask
  task automatic cmp_blank(logic [31:0] exp, logic [31:0] got);
    chk("blank", exp, got);
  endtask
  task automatic wr_reg(logic [3:0] a, logic [31:0] d, logic [7:0] k);
    if (k != 8'h00) ack_q.push_back({24'h0, k});
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [3:0] a, logic [31:0] e);
    rd_q.push_back(e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic exp_pulse(int ticks, int id, int lv);
    pulse_q.push_back(ticks * 4 + id * 2 + lv);
  endtask
  task automatic wait_sig(int w, int lim);
    int k;
    k = 0;
    while (sig[w] !== 1'b1 && k < lim) begin
      @(posedge clk);
      k++;
    end
    if (k >= lim) chk("wait", 32'h1, 32'h0);
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Result watcher: read data, acknowledges and line pulses
  always @(posedge clk) rd_prev <= rd;
  always @(negedge clk) begin
    if (rd_prev) cmp_rdata(rd_q.pop_front(), rdata);
    if (ack_valid !== 1'b0) begin
      cmp_ack(ack_q.size() ? ack_q.pop_front() : 32'hDEAD, {24'h0, ack_type});
    end
    for (int i = 0; i < 2; i++) begin
      if (oes[i] === 1'b1) begin
        n[i]++;
        lvl[i] = lines[i];
      end else if (n[i] > 0) begin
        cmp_pulse(pulse_q.size() ? pulse_q.pop_front() : 32'hDEAD,
            ((n[i] + T / 2) / T) * 4 + i * 2 + lvl[i]);
        n[i] = 0;
      end
    end
  end
  initial begin
    #(20 * 20000);
    bad_count++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    host_set <= 1'b0;
    rd_reg(ADDR_SWITCH_CFG, 32'h0004_2000);
    rd_reg(ADDR_STATUS, 32'h5EF1_0000);
    rd_reg(ADDR_WDOG, 32'h0);
    rd_reg(4'h7, 32'h0);
    wr_reg(ADDR_STATUS, 32'hFF, 8'h00);
    wr_reg(4'h9, $random(seed), 8'h00);
    // Key-hold restart with host up
    wr_reg(ADDR_SWITCH_CFG, 32'h21, ACK_SWITCH_CFG);
    exp_pulse(32, 0, 0);
    confirm <= 1'b1;
    wait_sig(0, 140 * T);
    confirm <= 1'b0;
    wait_sig(2, 40 * T);
    wr_reg(ADDR_WDOG, 32'h5, 8'h00);
    wait_sig(3, 4 * T);
    rd_reg(ADDR_SWITCH_CFG, 32'h0004_2021);
    // Key-hold shutdown, random length, inverted power line
    len = 2 + ($unsigned($random(seed)) % 16);
    wr_reg(ADDR_SWITCH_CFG, 32'h0001_0084 | (len << 8), ACK_SWITCH_CFG);
    exp_pulse(len, 1, 1);
    cancel <= 1'b1;
    wait_sig(1, 140 * T);
    cancel <= 1'b0;
    wait_sig(4, (len + 4) * T);
    // Key-press wake with blanking while host is down
    wr_reg(ADDR_SWITCH_CFG, 32'h51, ACK_SWITCH_CFG);
    repeat (4) @(posedge clk);
    cmp_blank(32'h3, {30'h0, blank, bl_off});
    exp_pulse(len, 1, 0);
    confirm <= 1'b1;
    wait_sig(1, 12 * T);
    confirm <= 1'b0;
    wait_sig(5, (len + 4) * T);
    repeat (8 * T) @(posedge clk);
    cmp_blank(32'h0, {30'h0, blank, bl_off});
    // Shutdown extended while cancel stays held; reset line set to drive high
    wr_reg(ADDR_SWITCH_CFG, 32'h0001_0482, ACK_SWITCH_CFG);
    exp_pulse(164, 1, 0);
    cancel <= 1'b1;
    wait_sig(4, 320 * T);
    cancel <= 1'b0;
    host_set <= 1'b1;
    @(posedge clk);
    host_set <= 1'b0;
    wait_sig(3, 4 * T);
    // Watchdog expiry, no second restart, disable
    wr_reg(ADDR_WDOG, 32'h2, ACK_WDOG);
    rd_reg(ADDR_STATUS, 32'h5EF1_0282);
    exp_pulse(32, 0, 1);
    wait_sig(0, 66 * T);
    repeat (34 * T) @(posedge clk);
    rd_reg(ADDR_WDOG, 32'h0);
    repeat (100 * T) @(posedge clk);
    wr_reg(ADDR_WDOG, 32'h1, ACK_WDOG);
    wr_reg(ADDR_WDOG, 32'h0, ACK_WDOG);
    rd_reg(ADDR_ACK, 32'h5D);
    repeat (40 * T) @(posedge clk);
    // Sense source taken from the dedicated pin
    wr_reg(ADDR_SWITCH_CFG, 32'h0002_0010, ACK_SWITCH_CFG);
    sense_pin <= 1'b0;
    repeat (4) @(posedge clk);
    cmp_blank(32'h3, {30'h0, blank, bl_off});
    rd_reg(ADDR_SWITCH_CFG, 32'h0000_0410);
    repeat (4) @(posedge clk);
    print_verdict();
  end
endmodule
